// [design/conv_scheduler.v]
// Conversion interval timer, one-shot handling and busy tracking
`timescale 1ns/1ps
`include "temp_monitor_defines.vh"
module conv_scheduler #(
   parameter BASE_CYCLES = `CONV_BASE_MS * `CLK_KHZ
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire [2:0] rate_code,
   input  wire       standby,
   input  wire       one_shot,
   input  wire       result_valid,
   output reg        conv_start_q,
   output reg        busy_q,
   output wire       result_take
);
   reg  [31:0] pre_q;
   reg  [7:0]  tick_cnt_q;
   reg         one_shot_q;
   wire        tick;
   wire [7:0]  interval;
   wire        fire;
   wire        abort;

   // Base tick every 125 ms; interval is 2^(7-code) ticks
   assign tick     = (pre_q == BASE_CYCLES - 1);
   assign interval = 8'h01 << (`RATE_MAX_CODE - rate_code);
   assign fire     = !standby && tick && (tick_cnt_q + 8'h01 >= interval);
   // Standby kills a periodic conversion without writing a result
   assign abort    = standby && !one_shot_q;
   assign result_take = result_valid && busy_q && !abort;

   // Prescaler and interval counter; cleared in standby
   always @(posedge clk) begin
      if (!nrst) begin
         pre_q      <= 32'h0;
         tick_cnt_q <= 8'h00;
      end else if (standby) begin
         pre_q      <= 32'h0;
         tick_cnt_q <= 8'h00;
      end else begin
         pre_q <= tick ? 32'h0 : pre_q + 32'h1;
         if (fire)
            tick_cnt_q <= 8'h00;
         else if (tick)
            tick_cnt_q <= tick_cnt_q + 8'h01;
      end
   end

   // Start pulse, busy flag and one-shot ownership
   always @(posedge clk) begin
      if (!nrst) begin
         conv_start_q <= 1'b0;
         busy_q       <= 1'b0;
         one_shot_q   <= 1'b0;
      end else begin
         conv_start_q <= fire || (one_shot && !busy_q);
         if (one_shot && !busy_q) begin
            busy_q     <= 1'b1;
            one_shot_q <= 1'b1;
         end else if (fire) begin
            busy_q <= 1'b1;
         end else if (result_valid || abort) begin
            // Result or abort ends the conversion; busy and one-shot ownership clear
            busy_q     <= 1'b0;
            one_shot_q <= 1'b0;
         end
      end
   end
endmodule // conv_scheduler

// [design/temp_monitor_ctrl.v]
// Serial slave, control registers and limit logic of the temperature monitor
`timescale 1ns/1ps
`include "temp_monitor_defines.vh"
module temp_monitor_ctrl #(
   parameter CONV_BASE_CYCLES = `CONV_BASE_MS * `CLK_KHZ
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       serial_clock_line,
   input  wire       serial_data_line_in,
   output reg        serial_data_line_out,
   output reg        serial_data_line_oe_n,
   input  wire [1:0] addr_strap_pin_a,
   input  wire [1:0] addr_strap_pin_b,
   input  wire       standby_pin_n,
   input  wire       result_valid,
   input  wire [7:0] local_result,
   input  wire [7:0] remote_result,
   output wire       conv_start,
   output reg  [7:0] local_value_q,
   output reg  [7:0] remote_value_q,
   output reg  [3:0] trip_q,
   output reg        alarm_out,
   output reg        alarm_oe_n,
   output reg        standby_q
);
   // One-hot serial states
   localparam S_IDLE = 7'h01;
   localparam S_ADDR = 7'h02;
   localparam S_AACK = 7'h04;
   localparam S_WDAT = 7'h08;
   localparam S_WACK = 7'h10;
   localparam S_RDAT = 7'h20;
   localparam S_RACK = 7'h40;

   reg  [2:0] scl_sync_q;
   reg  [2:0] sda_sync_q;
   reg  [1:0] stb_sync_q;
   reg  [1:0] stra_sync_q;
   reg  [1:0] stra2_sync_q;
   reg  [1:0] strb_sync_q;
   reg  [1:0] strb2_sync_q;
   reg  [1:0] strap_cnt_q;
   reg        strap_done_q;
   reg  [6:0] slave_addr_q;

   reg  [6:0] state_q;
   reg  [3:0] bit_cnt_q;
   reg  [7:0] shift_q;
   reg        byte_idx_q;
   reg  [7:0] pointer_q;
   reg        wr_req_q;
   reg  [7:0] wr_byte_q;

   reg  [7:0] config_q;
   reg  [7:0] rate_q;
   reg  [7:0] local_high_q;
   reg  [7:0] local_low_q;
   reg  [7:0] remote_high_q;
   reg  [7:0] remote_low_q;
   reg        one_shot_req_q;
   reg  [7:0] rd_data;
   reg  [6:0] addr_base;

   wire       scl;
   wire       sda;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_cond;
   wire       stop_cond;
   wire       standby;
   wire       busy;
   wire       result_take;

   // Pin synchronisers; only stage two and later feed logic
   always @(posedge clk) begin
      if (!nrst) begin
         scl_sync_q   <= 3'h7;
         sda_sync_q   <= 3'h7;
         stb_sync_q   <= 2'h3;
         stra_sync_q  <= 2'h0;
         stra2_sync_q <= 2'h0;
         strb_sync_q  <= 2'h0;
         strb2_sync_q <= 2'h0;
      end else begin
         scl_sync_q   <= {scl_sync_q[1:0], serial_clock_line};
         sda_sync_q   <= {sda_sync_q[1:0], serial_data_line_in};
         stb_sync_q   <= {stb_sync_q[0], standby_pin_n};
         stra_sync_q  <= addr_strap_pin_a;
         stra2_sync_q <= stra_sync_q;
         strb_sync_q  <= addr_strap_pin_b;
         strb2_sync_q <= strb_sync_q;
      end
   end

   assign scl        = scl_sync_q[1];
   assign sda        = sda_sync_q[1];
   assign scl_rise   = scl && !scl_sync_q[2];
   assign scl_fall   = !scl && scl_sync_q[2];
   assign start_cond = scl && scl_sync_q[2] && !sda && sda_sync_q[2];
   assign stop_cond  = scl && scl_sync_q[2] && sda && !sda_sync_q[2];

   // Straps map to a base per pin a plus an offset per pin b
   always @* begin
      case (stra2_sync_q)
         `STRAP_LOW:  addr_base = `ADDR_BASE_LOW;
         `STRAP_OPEN: addr_base = `ADDR_BASE_OPEN;
         default:     addr_base = `ADDR_BASE_HIGH;
      endcase
   end

   // Straps are caught once after reset settles, then never again
   always @(posedge clk) begin
      if (!nrst) begin
         strap_cnt_q  <= 2'h0;
         strap_done_q <= 1'b0;
         slave_addr_q <= `ADDR_BASE_LOW;
      end else if (!strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == `STRAP_SETTLE) begin
            strap_done_q <= 1'b1;
            slave_addr_q <= addr_base
                            + {5'h00, strb2_sync_q};
         end
      end
   end

   // Read mux; write-only and unknown locations read as zero
   always @* begin
      case (pointer_q)
         `RD_LOCAL_VALUE:  rd_data = local_value_q;
         `RD_REMOTE_VALUE: rd_data = remote_value_q;
         `RD_STATUS:       rd_data = {busy, trip_q, 3'h0};
         `RD_CONFIG:       rd_data = config_q;
         `RD_CONV_RATE:    rd_data = rate_q;
         `RD_LOCAL_HIGH:   rd_data = local_high_q;
         `RD_LOCAL_LOW:    rd_data = local_low_q;
         `RD_REMOTE_HIGH:  rd_data = remote_high_q;
         `RD_REMOTE_LOW:   rd_data = remote_low_q;
         default:          rd_data = `UNMAPPED_READ;
      endcase
   end

   // Serial slave: sample on clock rise, change data on clock fall
   always @(posedge clk) begin
      if (!nrst) begin
         state_q               <= S_IDLE;
         bit_cnt_q             <= 4'h0;
         shift_q               <= 8'h00;
         byte_idx_q            <= 1'b0;
         pointer_q             <= `RST_POINTER;
         wr_req_q              <= 1'b0;
         wr_byte_q             <= 8'h00;
         serial_data_line_out  <= 1'b0;
         serial_data_line_oe_n <= 1'b1;
      end else begin
         wr_req_q <= 1'b0;
         if (start_cond) begin
            // A new START always restarts addressing
            state_q               <= S_ADDR;
            bit_cnt_q             <= 4'h0;
            serial_data_line_oe_n <= 1'b1;
         end else if (stop_cond) begin
            state_q               <= S_IDLE;
            serial_data_line_oe_n <= 1'b1;
         end else begin
            case (state_q)
               S_IDLE: begin
                  serial_data_line_oe_n <= 1'b1;
               end
               S_ADDR: begin
                  if (scl_rise) begin
                     shift_q   <= {shift_q[6:0], sda};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     if (shift_q[7:1] == slave_addr_q) begin
                        state_q               <= S_AACK;
                        serial_data_line_oe_n <= 1'b0;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     bit_cnt_q  <= 4'h0;
                     byte_idx_q <= 1'b0;
                     if (shift_q[0]) begin
                        // Read: first data bit goes out now
                        state_q               <= S_RDAT;
                        shift_q               <= rd_data;
                        serial_data_line_oe_n <= rd_data[7];
                     end else begin
                        state_q               <= S_WDAT;
                        serial_data_line_oe_n <= 1'b1;
                     end
                  end
               end
               S_WDAT: begin
                  if (scl_rise) begin
                     shift_q   <= {shift_q[6:0], sda};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     state_q               <= S_WACK;
                     serial_data_line_oe_n <= 1'b0;
                     if (!byte_idx_q) begin
                        pointer_q  <= shift_q;
                        byte_idx_q <= 1'b1;
                     end else begin
                        // Extra bytes rewrite the same location
                        wr_req_q  <= 1'b1;
                        wr_byte_q <= shift_q;
                     end
                  end
               end
               S_WACK: begin
                  if (scl_fall) begin
                     state_q               <= S_WDAT;
                     bit_cnt_q             <= 4'h0;
                     serial_data_line_oe_n <= 1'b1;
                  end
               end
               S_RDAT: begin
                  if (scl_fall) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == 4'h7) begin
                        state_q               <= S_RACK;
                        serial_data_line_oe_n <= 1'b1;
                     end else begin
                        shift_q               <= {shift_q[6:0], 1'b0};
                        serial_data_line_oe_n <= shift_q[6];
                     end
                  end
               end
               S_RACK: begin
                  // NACK ends the read; wait for STOP or START
                  if (scl_rise && sda) begin
                     state_q <= S_IDLE;
                  end else if (scl_fall) begin
                     state_q               <= S_RDAT;
                     bit_cnt_q             <= 4'h0;
                     shift_q               <= rd_data;
                     serial_data_line_oe_n <= rd_data[7];
                  end
               end
               default: begin
                  state_q               <= S_IDLE;
                  serial_data_line_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // Register writes from the second byte of a write transfer
   always @(posedge clk) begin
      if (!nrst) begin
         config_q       <= `RST_CONFIG;
         rate_q         <= `RST_CONV_RATE;
         local_high_q   <= `RST_HIGH_LIMIT;
         local_low_q    <= `RST_LOW_LIMIT;
         remote_high_q  <= `RST_HIGH_LIMIT;
         remote_low_q   <= `RST_LOW_LIMIT;
         one_shot_req_q <= 1'b0;
      end else begin
         one_shot_req_q <= 1'b0;
         if (wr_req_q) begin
            case (pointer_q)
               `WR_CONFIG: begin
                  // Only mask and standby bits exist
                  config_q <= {wr_byte_q[`CFG_MASK_BIT],
                               wr_byte_q[`CFG_STANDBY_BIT],
                               6'h00};
               end
               `WR_CONV_RATE:   rate_q        <= wr_byte_q;
               `WR_LOCAL_HIGH:  local_high_q  <= wr_byte_q;
               `WR_LOCAL_LOW:   local_low_q   <= wr_byte_q;
               `WR_REMOTE_HIGH: remote_high_q <= wr_byte_q;
               `WR_REMOTE_LOW:  remote_low_q  <= wr_byte_q;
               `WR_ONE_SHOT: begin
                  // Data ignored; only with config standby and pin high
                  one_shot_req_q <= config_q[`CFG_STANDBY_BIT]
                                    && stb_sync_q[1];
               end
               default: begin
                  one_shot_req_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Either source of standby stops the converter
   assign standby = config_q[`CFG_STANDBY_BIT] || !stb_sync_q[1];

   conv_scheduler #(
      .BASE_CYCLES  (CONV_BASE_CYCLES)
   ) u_sched (
      .clk          (clk),
      .nrst         (nrst),
      .rate_code    (rate_q[`RATE_MSB:`RATE_LSB]),
      .standby      (standby),
      .one_shot     (one_shot_req_q),
      .result_valid (result_valid),
      .conv_start_q (conv_start),
      .busy_q       (busy),
      .result_take  (result_take)
   );

   // Values update only from accepted results, so standby holds them;
   // a pin standby also drops a one-shot result still in flight
   always @(posedge clk) begin
      if (!nrst) begin
         local_value_q  <= `RST_VALUE;
         remote_value_q <= `RST_VALUE;
         standby_q      <= 1'b0;
      end else begin
         standby_q <= standby;
         if (result_take && stb_sync_q[1]) begin
            local_value_q  <= local_result;
            remote_value_q <= remote_result;
         end
      end
   end

   // Signed, strict comparisons; alarm pin is open drain, low active
   always @(posedge clk) begin
      if (!nrst) begin
         trip_q     <= 4'h0;
         alarm_out  <= 1'b0;
         alarm_oe_n <= 1'b1;
      end else begin
         trip_q[3] <= $signed(local_value_q) > $signed(local_high_q);
         trip_q[2] <= $signed(local_value_q) < $signed(local_low_q);
         trip_q[1] <= $signed(remote_value_q) > $signed(remote_high_q);
         trip_q[0] <= $signed(remote_value_q) < $signed(remote_low_q);
         alarm_oe_n <= !((|trip_q) && !config_q[`CFG_MASK_BIT]);
      end
   end
endmodule // temp_monitor_ctrl

// [design/temp_monitor_defines.vh]
// Constants for the two-channel temperature monitor control block
`ifndef TEMP_MONITOR_DEFINES_VH
`define TEMP_MONITOR_DEFINES_VH

// Timing
`define CLK_KHZ          50000
`define CONV_BASE_MS     125
`define RATE_MAX_CODE    3'h7

// Read locations
`define RD_LOCAL_VALUE   8'h00
`define RD_REMOTE_VALUE  8'h01
`define RD_STATUS        8'h02
`define RD_CONFIG        8'h03
`define RD_CONV_RATE     8'h04
`define RD_LOCAL_HIGH    8'h05
`define RD_LOCAL_LOW     8'h06
`define RD_REMOTE_HIGH   8'h07
`define RD_REMOTE_LOW    8'h08
// Write locations
`define WR_CONFIG        8'h09
`define WR_CONV_RATE     8'h0a
`define WR_LOCAL_HIGH    8'h0b
`define WR_LOCAL_LOW     8'h0c
`define WR_REMOTE_HIGH   8'h0d
`define WR_REMOTE_LOW    8'h0e
`define WR_ONE_SHOT      8'h0f

// Reset values
`define RST_VALUE        8'h80
`define RST_CONFIG       8'h00
`define RST_CONV_RATE    8'h02
`define RST_HIGH_LIMIT   8'h7f
`define RST_LOW_LIMIT    8'hc9
`define RST_POINTER      8'h00
`define UNMAPPED_READ    8'h00

// Field positions
`define CFG_MASK_BIT     7
`define CFG_STANDBY_BIT  6
`define STAT_BUSY_BIT    7
`define RATE_LSB         0
`define RATE_MSB         2

// Strap codes and address bases
`define STRAP_LOW        2'h0
`define STRAP_OPEN       2'h1
`define STRAP_HIGH       2'h2
`define ADDR_BASE_LOW    7'h18
`define ADDR_BASE_OPEN   7'h29
`define ADDR_BASE_HIGH   7'h4c
`define STRAP_SETTLE     2'h3

`endif

// [verification/smbus_host_model.sv]
// Behavioural SMBus host: drives the clock, pulls data low
`timescale 1ns/1ps
module smbus_host_model (
   input  wire clk,
   input  wire sda,
   output reg  scl,
   output reg  sda_n
);
   // Idle bus: clock high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda_n = 1'b1;
   end

   // Slow half phase so the slave syncs every edge
   task automatic drive(input logic c, input logic dn);
      scl = c;
      sda_n = dn;
      repeat (8) @(negedge clk);
   endtask

   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      drive(1'b0, b);
      drive(1'b1, b);
      r = sda;
      drive(1'b0, b);
   endtask

   // Eight bits MSB first, then the acknowledge clock
   task automatic xfer(input logic [7:0] d, input logic ai,
                       output logic [7:0] q, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ai, ao);
   endtask

   task automatic start;
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
      drive(1'b0, 1'b0);
   endtask

   task automatic stop;
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
   endtask

   // Write: pointer byte, optional data byte; gives up on a NACK
   task automatic wr(input logic [6:0] a, input logic [7:0] p,
                     input logic two, input logic [7:0] d,
                     output logic nak);
      logic [7:0] q;
      logic       n;
      start;
      xfer({a, 1'b0}, 1'b1, q, nak);
      n = 1'b0;
      if (!nak) xfer(p, 1'b1, q, n);
      if (!nak && !n && two) xfer(d, 1'b1, q, n);
      nak = nak | n;
      stop;
   endtask

   // Read one byte; own START so direction never mixes
   task automatic rd(input logic [6:0] a, output logic [7:0] q,
                     output logic nak);
      logic n;
      start;
      xfer({a, 1'b1}, 1'b1, q, nak);
      if (!nak) xfer(8'hff, 1'b1, q, n);
      stop;
   endtask
endmodule // smbus_host_model

// [verification/tb.sv]
// Testbench: SMBus host traffic against the monitor control block
`timescale 1ns/1ps
module tb;
   localparam int BASE = 16;
   logic       clk;
   logic       nrst;
   logic [1:0] strap_a;
   logic [1:0] strap_b;
   logic       standby_pin_n_n;
   logic [2:0] rv_pipe = 3'h0;
   logic [7:0] loc_res;
   logic [7:0] rem_res;
   logic [6:0] dev;
   logic [7:0] q;
   logic       nak;
   wire        scl;
   wire        host_sda_n;
   wire        sda;
   wire        sda_out;
   wire        sda_oe_n;
   wire        conv_start;
   wire  [7:0] loc_val;
   wire  [7:0] rem_val;
   wire  [3:0] trip;
   wire        alarm_oe_n;
   wire        alarm_lvl;
   wire        standby_pin_n_q;
   int         err_count;
   int         n_compared;
   int         n_conv = 0;
   int         cyc = 0;
   int         n0;
   int         d;
   logic [6:0] base [3] = '{7'h18, 7'h29, 7'h4c};
   logic [7:0] rst_tab [6] = '{8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
   logic [7:0] lr [4] = '{8'h32, 8'h33, 8'h13, 8'h20};
   logic [7:0] rr [4] = '{8'hf6, 8'h05, 8'hf5, 8'hef};
   logic [3:0] et [4] = '{4'h0, 4'ha, 4'h4, 4'h1};

   // Open-drain data line with pull-up
   assign sda = host_sda_n & (sda_oe_n | sda_out);

   temp_monitor_ctrl #(.CONV_BASE_CYCLES(BASE)) dut (
      .clk(clk),
      .nrst(nrst),
      .serial_clock_line(scl),
      .serial_data_line_in(sda),
      .serial_data_line_out(sda_out),
      .serial_data_line_oe_n(sda_oe_n),
      .addr_strap_pin_a(strap_a),
      .addr_strap_pin_b(strap_b),
      .standby_pin_n(standby_pin_n_n),
      .result_valid(rv_pipe[2]),
      .local_result(loc_res),
      .remote_result(rem_res),
      .conv_start(conv_start),
      .local_value_q(loc_val),
      .remote_value_q(rem_val),
      .trip_q(trip),
      .alarm_out(alarm_lvl),
      .alarm_oe_n(alarm_oe_n),
      .standby_q(standby_pin_n_q)
   );

   smbus_host_model host (
      .clk(clk),
      .sda(sda),
      .scl(scl),
      .sda_n(host_sda_n)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Analog stand-in answers 3 cycles on; also run-length guard
   always @(negedge clk) begin
      rv_pipe <= {rv_pipe[1:0], conv_start};
      n_conv <= n_conv + (conv_start ? 1 : 0);
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         err_count++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] p, input logic [7:0] v);
      host.wr(dev, p, 1'b1, v, nak);
      chk(nak, 1'b0);
   endtask

   task automatic rnow(input logic [7:0] e);
      host.rd(dev, q, nak);
      chk(q, e);
   endtask

   task automatic rreg(input logic [7:0] p, input logic [7:0] e);
      host.wr(dev, p, 1'b0, 8'h00, nak);
      chk(nak, 1'b0);
      rnow(e);
   endtask

   // Bounded wait for the next conversion request
   task automatic wait1;
      int k;
      k = n_conv + 1;
      for (int i = 0; i < 9000 && n_conv < k; i++) @(negedge clk);
   endtask

   task automatic convs(input int n);
      repeat (n) wait1;
      repeat (8) @(negedge clk);
   endtask

   task automatic do_reset;
      nrst = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (12) @(negedge clk);
   endtask

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      strap_a = 2'h0;
      strap_b = 2'h0;
      standby_pin_n_n = 1'b1;
      loc_res = 8'h19;
      rem_res = 8'h32;
      err_count = 0;
      n_compared = 0;
      // Every strap pair, moved after capture
      for (int a = 0; a < 3; a++) begin
         for (int b = 0; b < 3; b++) begin
            strap_a = 2'(a);
            strap_b = 2'(b);
            do_reset;
            chk(loc_val, 8'h80);
            strap_a = 2'((a + 1) % 3);
            strap_b = 2'((b + 1) % 3);
            dev = base[a] + 7'(b);
            rreg(8'h03, 8'h00);
            host.rd(base[(a + 1) % 3] + 7'((b + 1) % 3), q, nak);
            chk(nak, 1'b1);
         end
      end
      $display("test straps done");
      for (int i = 0; i < 6; i++) rreg(8'h03 + 8'(i), rst_tab[i]);
      rreg(8'h0f, 8'h00);
      $display("test defaults done");
      // Reserved bits dropped; stray writes change nothing
      wreg(8'h09, 8'hff);
      rreg(8'h03, 8'hc0);
      chk(standby_pin_n_q, 1'b1);
      wreg(8'h03, 8'h00);
      wreg(8'h11, 8'h00);
      rnow(8'h00);
      rreg(8'h03, 8'hc0);
      $display("test config done");
      // Standby by bit: values frozen, one-shot runs exactly once
      loc_res = 8'h2a;
      rem_res = 8'h33;
      repeat (600) @(negedge clk);
      chk(loc_val, 8'h19);
      n0 = n_conv;
      wreg(8'h0f, 8'h5a);
      repeat (600) @(negedge clk);
      chk(16'(n_conv - n0), 16'h1);
      chk(loc_val, 8'h2a);
      chk(rem_val, 8'h33);
      chk(standby_pin_n_q, 1'b1);
      $display("test one-shot done");
      // Pin standby overrides bit and one-shot
      standby_pin_n_n = 1'b0;
      loc_res = 8'h44;
      wreg(8'h0f, 8'h00);
      wreg(8'h09, 8'h00);
      repeat (600) @(negedge clk);
      chk(16'(n_conv - n0), 16'h1);
      chk(standby_pin_n_q, 1'b1);
      chk(loc_val, 8'h2a);
      standby_pin_n_n = 1'b1;
      convs(2);
      chk(loc_val, 8'h44);
      chk(standby_pin_n_q, 1'b0);
      $display("test pin standby done");
      // Every rate code: read back and request spacing
      for (int c = 0; c < 8; c++) begin
         wreg(8'h0a, 8'(c));
         rreg(8'h04, 8'(c));
         wait1;
         wait1;
         d = cyc;
         wait1;
         chk(16'(cyc - d), 16'(BASE << (7 - c)));
      end
      $display("test rates done");
      // Strict compares, signed limits
      wreg(8'h0b, 8'h32);
      wreg(8'h0c, 8'h14);
      wreg(8'h0d, 8'hf6);
      wreg(8'h0e, 8'hf0);
      rreg(8'h07, 8'hf6);
      for (int i = 0; i < 4; i++) begin
         loc_res = lr[i];
         rem_res = rr[i];
         convs(2);
         chk(trip, et[i]);
         chk({alarm_lvl, alarm_oe_n}, {1'b0, et[i] == 4'h0});
      end
      wreg(8'h09, 8'h80);
      convs(2);
      chk(alarm_oe_n, 1'b1);
      chk(standby_pin_n_q, 1'b0);
      $display("test limits done");
      report_and_stop;
   end
endmodule // tb

// [verification/temp_monitor_asserts.sv]
// Port-level checker for the temperature monitor control block
`timescale 1ns/1ps
module temp_monitor_checker #(
   parameter CONV_BASE_CYCLES = 16
) (
   input wire       clk,
   input wire       nrst,
   input wire       serial_clock_line,
   input wire       serial_data_line_oe_n,
   input wire       standby_pin_n,
   input wire       conv_start,
   input wire [7:0] local_value_q,
   input wire [7:0] remote_value_q,
   input wire [3:0] trip_q,
   input wire       alarm_oe_n,
   input wire       standby_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Requests are single pulses, followed by at least eight request-free cycles
   AST_CONV_SPACING: assert property (
      conv_start |=> !conv_start [*8])
      else $error("conversion requests too close");
   // Pin standby, once synchronised, blocks every request
   AST_PIN_BLOCKS_CONV: assert property (
      !standby_pin_n [*6] |-> !conv_start)
      else $error("conversion while pin holds standby");
   // Values frozen while the pin holds standby
   AST_VALUES_HOLD: assert property (
      !standby_pin_n [*6] |-> $stable(local_value_q) && $stable(remote_value_q))
      else $error("value changed in standby");
   // Alarm only ever follows a tripped limit
   AST_ALARM_CAUSE: assert property (
      !alarm_oe_n |-> $past(trip_q) != 4'h0)
      else $error("alarm without trip");
   AST_ALARM_FOLLOWS: assert property (
      trip_q == 4'h0 |=> alarm_oe_n)
      else $error("alarm stays with no trip");
   // Slave drives data changes only in the clock low phase
   AST_DATA_LOW_PHASE: assert property (
      $changed(serial_data_line_oe_n) |-> !serial_clock_line)
      else $error("data line moved while clock high");
   AST_BIT_STANDS: assert property (
      $fell(serial_data_line_oe_n) |-> !serial_data_line_oe_n [*8])
      else $error("driven bit too short");
   // Everything but the remote value idle and at defaults straight after reset
   AST_RESET_IDLE: assert property (
      $rose(nrst) |-> serial_data_line_oe_n && alarm_oe_n && !conv_start
         && local_value_q == 8'h80 && trip_q == 4'h0 && !standby_q)
      else $error("not idle after reset");

   // Main scenarios reached
   COV_ONE_SHOT: cover property (standby_q && conv_start);
   COV_ALARM: cover property (!alarm_oe_n);
   COV_ACK: cover property ($fell(serial_data_line_oe_n));
endmodule // temp_monitor_checker

bind temp_monitor_ctrl temp_monitor_checker #(
   .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) u_checker (
   .clk(clk),
   .nrst(nrst),
   .serial_clock_line(serial_clock_line),
   .serial_data_line_oe_n(serial_data_line_oe_n),
   .standby_pin_n(standby_pin_n),
   .conv_start(conv_start),
   .local_value_q(local_value_q),
   .remote_value_q(remote_value_q),
   .trip_q(trip_q),
   .alarm_oe_n(alarm_oe_n),
   .standby_q(standby_q)
);
